/* rtl/ppp_top.sv */
// Purpose: Printer parallel port with APB register access.
// Assumes: APB master on clk; printer and select pins are asynchronous.
// Notes:   Zero-wait APB: pready rises in every access phase.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ppp_params.svh"
module ppp_top (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`PPP_AW-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    input  wire logic                  printer_port_select_n,
    input  wire logic                  printer_drive_enable_n,
    input  wire logic                  char_taken_n,
    input  wire logic                  media_out_flag,
    input  wire logic                  printer_busy,
    input  wire logic                  printer_online,
    input  wire logic                  printer_fault_n,
    output ppp_pkg::ppp_byte_t         printer_data_lines,
    output logic                       printer_data_oe,
    output logic                       printer_select_out_n,
    output logic                       printer_init_n,
    output logic                       auto_line_feed_n,
    output logic                       data_latch_pulse_n,
    output logic                       printer_irq_n,
    output logic                       printer_irq_oe
);
    import ppp_pkg::*;

    logic [`PPP_IN_W-1:0]    pins_s;
    logic [`PPP_IN_W-1:0]    pins_q;
    ppp_byte_t               data_reg;
    logic [`PPP_CTRL_W-1:0]  ctrl;
    logic [`PPP_EV_W-1:0]    irq_stat;
    logic [`PPP_EV_W-1:0]    irq_mask;
    logic [`PPP_EV_W-1:0]    events;
    logic [`PPP_EV_W-1:0]    next_irq_stat;
    logic [`PPP_ST_W-1:0]    status;
    logic [31:0]             next_prdata;
    logic                    next_pslverr;
    logic                    access;
    logic                    wr;
    logic                    rd;
    logic                    strobe_go;
    logic                    strobing;
    logic                    sent;

    // ------------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------------
    ppp_sync #(
        .W       (`PPP_IN_W),
        .RST_VAL (`PPP_SYNC_RST)
    ) u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({printer_port_select_n, printer_drive_enable_n,
                    printer_fault_n, printer_online, printer_busy,
                    media_out_flag, char_taken_n}),
        .sync_out (pins_s)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins_q <= `PPP_SYNC_RST;
        end else begin
            pins_q <= pins_s;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign access    = psel && penable && pready;
    assign wr        = access && pwrite;
    assign rd        = access && !pwrite;
    assign strobe_go = wr && (paddr == `PPP_ADDR_STROBE)
                       && pwdata[`PPP_STROBE_GO];

    // Status shows live pin levels, taken straight from the synchroniser output.
    assign status = {pins_s[`PPP_IN_FAULT_N], pins_s[`PPP_IN_ONLINE],
                     pins_s[`PPP_IN_BUSY], pins_s[`PPP_IN_MEDIA],
                     pins_s[`PPP_IN_TAKEN_N], strobing};           // [RULE15]

    always_comb begin
        next_prdata  = '0;
        next_pslverr = 1'b0;
        unique case (paddr)
            `PPP_ADDR_DATA:     next_prdata = {24'h000000, data_reg};
            `PPP_ADDR_STATUS:   next_prdata = {26'h0000000, status};
            `PPP_ADDR_CTRL:     next_prdata = {27'h0000000, ctrl};
            `PPP_ADDR_STROBE:   next_prdata = {31'h00000000, strobing};
            `PPP_ADDR_IRQ_STAT: next_prdata = {28'h0000000, irq_stat};
            `PPP_ADDR_IRQ_MASK: next_prdata = {28'h0000000, irq_mask};
            default:            next_pslverr = 1'b1;
        endcase
    end

    // Read data is taken in the setup cycle so it can come from a flop;
    // the trade-off is that a status edge in the access cycle is missed.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata  <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_reg <= `PPP_DATA_RST;
            ctrl     <= `PPP_CTRL_RST;
            irq_mask <= `PPP_EV_RST;
        end else if (wr) begin
            if (paddr == `PPP_ADDR_DATA) begin
                data_reg <= pwdata[7:0];
            end
            if (paddr == `PPP_ADDR_CTRL) begin
                ctrl <= pwdata[`PPP_CTRL_W-1:0];
            end
            if (paddr == `PPP_ADDR_IRQ_MASK) begin
                irq_mask <= pwdata[`PPP_EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Data latch strobe
    // ------------------------------------------------------------------
    ppp_strobe u_strobe (
        .clk                (clk),
        .nrst               (nrst),
        .start              (strobe_go),
        .data_latch_pulse_n (data_latch_pulse_n),
        .strobing           (strobing),
        .sent               (sent)
    );

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    always_comb begin
        events                = '0;
        events[`PPP_EV_TAKEN] = pins_q[`PPP_IN_TAKEN_N]
                                && !pins_s[`PPP_IN_TAKEN_N];
        events[`PPP_EV_FAULT] = pins_q[`PPP_IN_FAULT_N]
                                && !pins_s[`PPP_IN_FAULT_N];
        events[`PPP_EV_MEDIA] = !pins_q[`PPP_IN_MEDIA]
                                && pins_s[`PPP_IN_MEDIA];
        events[`PPP_EV_SENT]  = sent;
        next_irq_stat = irq_stat;
        // Only the bits that the read reported are cleared, so an event
        // landing between setup and access is not lost.
        if (rd && (paddr == `PPP_ADDR_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~prdata[`PPP_EV_W-1:0];
        end
        // A new event wins over the read that clears.
        next_irq_stat = next_irq_stat | events;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= `PPP_EV_RST;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Printer pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            printer_data_lines   <= `PPP_DATA_RST;
            printer_data_oe      <= 1'b0;
            printer_select_out_n <= 1'b1;
            printer_init_n       <= 1'b1;
            auto_line_feed_n     <= 1'b1;
            printer_irq_n        <= 1'b1;
            printer_irq_oe       <= 1'b0;
        end else begin
            printer_data_lines   <= data_reg;
            printer_data_oe      <= !pins_s[`PPP_IN_DRV_N]             // [RULE1]
                                    && !pins_s[`PPP_IN_SEL_N];         // [RULE2]
            printer_select_out_n <= !ctrl[`PPP_CTRL_SEL];              // [RULE8]
            printer_init_n       <= !ctrl[`PPP_CTRL_INIT];             // [RULE9]
            auto_line_feed_n     <= !ctrl[`PPP_CTRL_FEED];             // [RULE10]
            printer_irq_n        <= pins_s[`PPP_IN_TAKEN_N];           // [RULE12]
            printer_irq_oe       <= ctrl[`PPP_CTRL_IRQ_EN];            // [RULE13]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    drive_enable_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
        pins_s[`PPP_IN_DRV_N] |=> !printer_data_oe)
        else $error("Data lines driven while drive enable is high.");
    port_select_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
        printer_data_oe |-> !$past(pins_s[`PPP_IN_SEL_N]))
        else $error("Data lines driven while port is not selected.");
    select_out_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
        (wr && paddr == `PPP_ADDR_CTRL) |=> ##1
        printer_select_out_n == !$past(pwdata[`PPP_CTRL_SEL], 2))
        else $error("Select output does not follow control.");
    init_out_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
        $rose(ctrl[`PPP_CTRL_INIT]) |=> $fell(printer_init_n))
        else $error("Init output did not go low.");
    feed_out_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
        $fell(ctrl[`PPP_CTRL_FEED]) |=> $rose(auto_line_feed_n))
        else $error("Auto feed output did not release.");
    taken_irq_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE12]
        !pins_s[`PPP_IN_TAKEN_N] [*2] |-> !printer_irq_n)
        else $error("Printer interrupt pin not low on character taken.");
    irq_enable_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
        printer_irq_oe |-> $past(ctrl[`PPP_CTRL_IRQ_EN]))
        else $error("Printer interrupt pin driven while disabled.");
    status_read_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
        (psel && !penable && !pwrite && paddr == `PPP_ADDR_STATUS)
        |=> prdata[5:1] == $past(status[5:1]))
        else $error("Status read does not show pin levels.");
    drive_on_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
        (!pins_s[`PPP_IN_DRV_N] && !pins_s[`PPP_IN_SEL_N])
        |=> printer_data_oe)
        else $error("Data lines not driven while enabled and selected.");
    init_done_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
        $fell(ctrl[`PPP_CTRL_INIT]) |=> $rose(printer_init_n))
        else $error("Init output did not release.");
    feed_low_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
        $rose(ctrl[`PPP_CTRL_FEED]) |=> $fell(auto_line_feed_n))
        else $error("Auto feed output did not go low.");
    irq_float_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
        !ctrl[`PPP_CTRL_IRQ_EN] |=> !printer_irq_oe)
        else $error("Printer interrupt pin not released when disabled.");
    irq_idle_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE12]
        pins_s[`PPP_IN_TAKEN_N] [*2] |-> printer_irq_n)
        else $error("Printer interrupt pin low without character taken.");
    taken_event_a: assert property (@(posedge clk) disable iff (!nrst)
        $fell(pins_s[`PPP_IN_TAKEN_N]) |=> irq_stat[`PPP_EV_TAKEN])
        else $error("Character taken event not recorded.");
    ready_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        pready |=> !pready)
        else $error("Ready stood for more than one cycle.");
endmodule

/* rtl/ppp_params.svh */
// Purpose: Constants of the printer parallel port: addresses, fields, timing.
// Assumes: 100 MHz clock, APB with 8-bit byte addresses.
// Notes:   Included by every design module of the port, not by the package.
//
// Summary of operation
// RULE1: Printer data lines are driven only while the drive enable pin is low.
// RULE2: Printer data lines float whenever the host has not selected the port.
// RULE3: The printer pulls character-taken low when it took the last byte.
// RULE4: The printer raises the media-out flag when paper has run out.
// RULE5: The printer holds busy high while it cannot accept data.
// RULE6: The printer drives online high when it has been selected.
// RULE7: The printer drives fault low when it met an error.
// RULE8: The select output is low to select the printer and high otherwise.
// RULE9: The init output goes low to start the printer initialisation.
// RULE10: The auto line feed output is low when a feed follows each line.
// RULE11: The data latch output pulses low for at least 0.5 us per byte.
// RULE12: The printer interrupt pin goes low whenever character-taken is low.
// RULE13: Control bit 4 enables the printer interrupt pin, else it floats.
// RULE14: The host asserts the port select pin to address the port.
// RULE15: Busy, character-taken, media-out, online and fault read as status.
`ifndef PPP_PARAMS_SVH
`define PPP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PPP_AW             8
`define PPP_ADDR_DATA      8'h00
`define PPP_ADDR_STATUS    8'h04
`define PPP_ADDR_CTRL      8'h08
`define PPP_ADDR_STROBE    8'h0C
`define PPP_ADDR_IRQ_STAT  8'h10
`define PPP_ADDR_IRQ_MASK  8'h14

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PPP_CTRL_W         5
`define PPP_CTRL_SEL       0
`define PPP_CTRL_INIT      1
`define PPP_CTRL_FEED      2
`define PPP_CTRL_IRQ_EN    4
`define PPP_CTRL_RST       5'h00
`define PPP_DATA_RST       8'h00
`define PPP_STROBE_GO      0
`define PPP_EV_W           4
`define PPP_EV_TAKEN       0
`define PPP_EV_FAULT       1
`define PPP_EV_MEDIA       2
`define PPP_EV_SENT        3
`define PPP_EV_RST         4'h0
`define PPP_ST_W           6
`define PPP_ST_STROBING    0

// Synchroniser bit order and idle levels.
`define PPP_IN_W           7
`define PPP_IN_TAKEN_N     0
`define PPP_IN_MEDIA       1
`define PPP_IN_BUSY        2
`define PPP_IN_ONLINE      3
`define PPP_IN_FAULT_N     4
`define PPP_IN_DRV_N       5
`define PPP_IN_SEL_N       6
`define PPP_SYNC_RST       7'h71

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPP_CLK_MHZ        100
`define PPP_LATCH_NS       500
`define PPP_LATCH_CYC      ((`PPP_LATCH_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_CNT_W          7

`endif

/* rtl/ppp_pkg.sv */
// Purpose: Types shared by the printer parallel port modules.
// Assumes: Nothing beyond the constants header.
// Notes:   Numbers live in ppp_params.svh.
package ppp_pkg;
    typedef logic [7:0] ppp_byte_t;
    typedef enum logic {PPP_IDLE, PPP_LOW} ppp_strobe_e;
endpackage

/* rtl/ppp_sync.sv */
// Purpose: Two-flop synchroniser for the printer and host pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/10ps
`include "ppp_params.svh"
module ppp_sync #(
    parameter int              W       = `PPP_IN_W,
    parameter logic [W-1:0]    RST_VAL = `PPP_SYNC_RST
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [W-1:0]  async_in,
    output logic      [W-1:0]  sync_out
);
    import ppp_pkg::*;

    logic [W-1:0] meta;

    // ------------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                meta[i]     <= RST_VAL[i];
                sync_out[i] <= RST_VAL[i];
            end else begin
                meta[i]     <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end
endmodule

/* rtl/ppp_strobe.sv */
// Purpose: Timed low pulse on the printer data latch line.
// Assumes: start is a one-cycle pulse from clk logic.
// Notes:   A start while the pulse runs is ignored.
`timescale 1ns/10ps
`include "ppp_params.svh"
module ppp_strobe (
    input  wire logic  clk,
    input  wire logic  nrst,
    input  wire logic  start,
    output logic       data_latch_pulse_n,
    output logic       strobing,
    output logic       sent
);
    import ppp_pkg::*;

    ppp_strobe_e             state;
    logic [`PPP_CNT_W-1:0]   cnt;
    logic [`PPP_CNT_W-1:0]   low_len;

    // ------------------------------------------------------------------
    // Pulse timer
    // ------------------------------------------------------------------
    // The count covers the full low time so the printer always has the
    // minimum latch width, even if software restarts it at once.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state              <= PPP_IDLE;
            cnt                <= '0;
            data_latch_pulse_n <= 1'b1;
            sent               <= 1'b0;
        end else begin
            sent <= 1'b0;
            unique case (state)
                PPP_IDLE: begin
                    if (start) begin
                        state              <= PPP_LOW;
                        cnt                <= `PPP_CNT_W'(`PPP_LATCH_CYC - 1);
                        data_latch_pulse_n <= 1'b0;                // [RULE11]
                    end
                end
                PPP_LOW: begin
                    if (cnt == '0) begin
                        state              <= PPP_IDLE;
                        data_latch_pulse_n <= 1'b1;                // [RULE11]
                        sent               <= 1'b1;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    assign strobing = (state == PPP_LOW);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_len <= '0;
        end else if (data_latch_pulse_n) begin
            low_len <= '0;
        end else begin
            low_len <= low_len + 1'b1;
        end
    end

    latch_width_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE11]
        $rose(data_latch_pulse_n) |-> $past(low_len) >= `PPP_LATCH_CYC - 1)
        else $error("Data latch pulse too short.");
    latch_start_a: assert property (@(posedge clk) disable iff (!nrst) // [RULE11]
        (start && !strobing) |=> !data_latch_pulse_n [*8])
        else $error("Data latch pulse did not start on request.");
endmodule

/* testbench/ppp_printer_model.sv */
// Purpose: Behavioural printer on the far side of the parallel port.
// Assumes: Latch pulses end with a rising edge of latch_n on clk.
// Notes:   The acknowledge delay is set by the bench, 8 to 23 cycles.
`timescale 1ns/10ps
module ppp_printer_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] data_wire,
    input  wire logic       latch_n,
    input  wire logic       select_out_n,
    input  wire logic       paper_cmd,
    input  wire logic       err_cmd,
    input  wire logic [7:0] ack_delay,
    output logic            char_taken_n,
    output logic            media_out_flag,
    output logic            printer_busy,
    output logic            printer_online,
    output logic            printer_fault_n,
    output logic [7:0]      got_byte,
    output logic [7:0]      got_width
);
    logic [7:0] low_cnt;
    logic [7:0] wait_cnt;
    logic       latch_q;

    assign media_out_flag  = paper_cmd;
    assign printer_online  = !select_out_n;
    assign printer_fault_n = !err_cmd;

    // The byte is taken at the end of the pulse, so a short pulse or
    // floating lines show up as a wrong width or a wrong byte.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_q      <= 1'b1;
            low_cnt      <= 8'h00;
            wait_cnt     <= 8'h00;
            got_byte     <= 8'h00;
            got_width    <= 8'h00;
            char_taken_n <= 1'b1;
            printer_busy <= 1'b0;
        end else begin
            latch_q <= latch_n;
            if (!latch_n) begin
                low_cnt <= low_cnt + 8'h01;
            end
            if (latch_n && !latch_q) begin
                got_byte     <= data_wire;
                got_width    <= low_cnt;
                low_cnt      <= 8'h00;
                printer_busy <= 1'b1;
                wait_cnt     <= {4'h0, ack_delay[3:0]} + 8'h08;
            end else if (wait_cnt != 8'h00) begin
                wait_cnt     <= wait_cnt - 8'h01;
                char_taken_n <= (wait_cnt > 8'h08) || (wait_cnt == 8'h01);
                printer_busy <= (wait_cnt != 8'h01);
            end
        end
    end
endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the printer parallel port over APB.
// Assumes: Zero-wait APB slave, printer model on the pins.
// Notes:   Released data lines show the inverse of the byte.
`timescale 1ns/10ps
`include "ppp_params.svh"
module testbench;
    import ppp_pkg::*;
    logic               clk, nrst, psel, penable, pwrite;
    logic [`PPP_AW-1:0] paddr;
    logic [31:0]        pwdata, prdata, rd, b;
    logic               pready, pslverr, irq, err;
    logic               port_sel_n, drv_en_n, taken_n, media, busy;
    logic               online, fault_n, paper_cmd, err_cmd;
    ppp_byte_t          data_lines;
    logic               data_oe, sel_out_n, init_n, feed_n, latch_n;
    logic               pirq_n, pirq_oe, irq_wire;
    logic [7:0]         ack_delay, got_byte, got_width, data_wire;
    int                 mismatches, checks, seed, i;

    assign data_wire = data_oe ? data_lines : ~data_lines;
    assign irq_wire  = pirq_oe ? pirq_n : 1'b1;

    ppp_top ppp_top_inst (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .printer_port_select_n(port_sel_n), .printer_drive_enable_n(drv_en_n),
        .char_taken_n(taken_n), .media_out_flag(media), .printer_busy(busy),
        .printer_online(online), .printer_fault_n(fault_n),
        .printer_data_lines(data_lines), .printer_data_oe(data_oe),
        .printer_select_out_n(sel_out_n), .printer_init_n(init_n),
        .auto_line_feed_n(feed_n), .data_latch_pulse_n(latch_n),
        .printer_irq_n(pirq_n), .printer_irq_oe(pirq_oe));

    ppp_printer_model ppp_printer_model_inst (.clk(clk), .nrst(nrst),
        .data_wire(data_wire), .latch_n(latch_n), .select_out_n(sel_out_n),
        .paper_cmd(paper_cmd), .err_cmd(err_cmd), .ack_delay(ack_delay),
        .char_taken_n(taken_n), .media_out_flag(media), .printer_busy(busy),
        .printer_online(online), .printer_fault_n(fault_n),
        .got_byte(got_byte), .got_width(got_width));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle cycle behind.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        @(posedge clk);
    endtask

    task automatic wait_taken();
        int n;
        n = 0;
        while (taken_n !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    function automatic logic [31:0] stat_exp();
        return {26'h0, fault_n, online, busy, media, taken_n, 1'b0};
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 3;
        mismatches = 0;
        checks = 0;
        {nrst, psel, penable, pwrite, paper_cmd, err_cmd} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {port_sel_n, drv_en_n} = 2'b11;
        ack_delay = 8'h03;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmp({data_oe, sel_out_n, init_n, feed_n, latch_n, pirq_oe, irq},
            32'h3C);
        apb(1'b0, `PPP_ADDR_CTRL, 32'h0);
        cmp(rd, 32'h0);
        $display("test reset done");

        for (i = 0; i < 8; i++) begin
            b = $random(seed) & 32'h17;
            apb(1'b1, `PPP_ADDR_CTRL, b);
            repeat (3) @(posedge clk);
            cmp(sel_out_n, !b[0]);
            cmp(init_n, !b[1]);
            cmp(feed_n, !b[2]);
            cmp(pirq_oe, b[4]);
        end
        apb(1'b1, `PPP_ADDR_CTRL, 32'h11);
        $display("test control done");

        for (i = 3; i >= 0; i--) begin
            {port_sel_n, drv_en_n} <= i[1:0];
            repeat (4) @(posedge clk);
            cmp(data_oe, i == 0);
        end
        $display("test drive done");

        apb(1'b1, `PPP_ADDR_IRQ_MASK, 32'hF);
        for (i = 0; i < 4; i++) begin
            b = $random(seed);
            ack_delay <= b[15:8];
            apb(1'b1, `PPP_ADDR_DATA, b & 32'hFF);
            apb(1'b1, `PPP_ADDR_STROBE, 32'h1);
            apb(1'b1, `PPP_ADDR_STROBE, 32'h1);
            apb(1'b0, `PPP_ADDR_STROBE, 32'h0);
            cmp(rd, 32'h1);
            wait_taken();
            repeat (4) @(posedge clk);
            cmp(got_width, `PPP_LATCH_CYC);
            cmp(got_byte, b[7:0]);
            cmp(pirq_n, 1'b0);
            cmp(irq_wire, 1'b0);
            cmp(irq, 1'b1);
            apb(1'b0, `PPP_ADDR_IRQ_STAT, 32'h0);
            cmp(rd, 32'h9);
            repeat (2) @(posedge clk);
            cmp(irq, 1'b0);
        end
        $display("test strobe done");

        apb(1'b1, `PPP_ADDR_CTRL, 32'h01);
        apb(1'b1, `PPP_ADDR_IRQ_MASK, 32'h0);
        paper_cmd <= 1'b1;
        err_cmd   <= 1'b1;
        repeat (5) @(posedge clk);
        cmp(irq, 1'b0);
        cmp(irq_wire, 1'b1);
        apb(1'b1, `PPP_ADDR_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clk);
        cmp(irq, 1'b1);
        apb(1'b0, `PPP_ADDR_STATUS, 32'h0);
        cmp(rd, stat_exp());
        apb(1'b0, `PPP_ADDR_IRQ_STAT, 32'h0);
        cmp(rd, 32'h6);
        $display("test status done");

        apb(1'b0, 8'h18, 32'h0);
        cmp(err, 1'b1);
        cmp(rd, 32'h0);
        apb(1'b1, 8'h1C, 32'hFF);
        cmp(err, 1'b1);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
